// File: rtl/vmseq_flash_if.sv
// Script memory request and answer
`timescale 1ns/1ps
interface vmseq_flash_if;
  logic req;
  logic [vmseq_pkg::AW-1:0] addr;
  logic ack;
  logic [31:0] data;
  modport seq (output req, output addr, input ack, input data);
  modport mem (input req, input addr, output ack, output data);
endinterface

// File: rtl/vmseq_pkg.sv
// Constants and types for the voice macro sequencer
// Function
// - Play runs on the one selected channel or on all three.
// - Channel register at offset 0x0C chooses the next play channel.
// - Low bits 00 pick channel zero, 01 channel one; channels mix.
// - With nothing else selected, play runs on channel zero.
// - Mask branch jumps when pins and status match the mask.
// - Absolute jump always moves fetching to the given address.
// - Branch and jump targets may lie anywhere in flash.
// - Each channel has its own delay counter for pauses.
// - Wait-for-audio stalls the script until playback ends.
// - Pin jump register names the macro the next trigger starts.
// - A trigger during a macro preempts it with the pin's macro.
// - Edge register bit adds rising-edge triggers to falling ones.
// - Enable register gates each pin; 0x3f re-enables all.
// - Releasing a held pin with rising edge enabled starts its macro.
// - Sample rate is 32 kHz within one percent.
// - Power-on init macro runs after reset and software reset.
// - Wake-up macro runs on a trigger while powered down first.
// - Finish ends macro powered up; power-down ends it powered down.
// - Path and volume registers reset on entering power down.
package vmseq_pkg;
  localparam int NPIN = 6;
  localparam int NCH = 3;
  localparam int AW = 16;
  localparam logic [7:0] OFS_EDGE = 8'h02;
  localparam logic [7:0] OFS_TRGEN = 8'h03;
  localparam logic [7:0] OFS_CHAN = 8'h0c;
  localparam logic [7:0] OFS_PATH = 8'h10;
  localparam logic [7:0] OFS_VOL = 8'h14;
  localparam logic [7:0] OFS_MASK = 8'h18;
  localparam logic [7:0] OFS_STAT = 8'h1c;
  localparam logic [7:0] OFS_SWRST = 8'h20;
  localparam logic [7:0] OFS_JMP0 = 8'h40;
  localparam logic [7:0] RST_TRGEN = 8'h3f;
  localparam logic [7:0] RST_PATH = 8'h00;
  localparam logic [7:0] RST_VOL = 8'h00;
  localparam logic [7:0] MACRO_POI = 8'h00;
  localparam logic [7:0] MACRO_WAKE = 8'h01;
  localparam logic [1:0] CH_ALL = 2'b11;
  localparam logic [1:0] RESP_OK = 2'b00;
  localparam logic [1:0] RESP_ERR = 2'b10;
  localparam int CLK_HZ = 100_000_000;
  localparam int SAMPLE_HZ = 32_000;
  localparam int SAMPLE_DIV = CLK_HZ / SAMPLE_HZ;
  // Opcodes in bits 31:28 of a command word
  typedef enum logic [3:0] {
    OP_FINISH = 4'b0000,
    OP_PLAY = 4'b0001,
    OP_CFG = 4'b0010,
    OP_SILENCE = 4'b0011,
    OP_WAIT = 4'b0100,
    OP_MBR = 4'b0101,
    OP_JMP = 4'b0110,
    OP_EXE = 4'b0111,
    OP_PD = 4'b1000,
    OP_DELAY = 4'b1001
  } vmseq_op_t;
  typedef enum logic [2:0] {
    ST_OFF = 3'b000,
    ST_FETCH = 3'b001,
    ST_WAIT = 3'b010,
    ST_EXEC = 3'b011,
    ST_TIMER = 3'b100,
    ST_AUDIO = 3'b101
  } vmseq_state_t;
endpackage

// File: rtl/vmseq_script_rom.sv
// Script store with a registered read port
`timescale 1ns/1ps
module vmseq_script_rom (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Fetch port
  vmseq_flash_if.mem fl,
  // Load port
  input wire logic load_we,
  input wire logic [vmseq_pkg::AW-1:0] load_addr,
  input wire logic [31:0] load_data
);
  import vmseq_pkg::*;
  logic [31:0] mem [0:(1<<AW)-1];
  logic [31:0] data_ff;
  logic ack_ff;
  assign fl.data = data_ff;
  assign fl.ack = ack_ff;
  always_ff @(posedge ref_clk) begin
    if (load_we) begin
      mem[load_addr] <= load_data;
    end
    data_ff <= mem[fl.addr];
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= fl.req & ~ack_ff;
    end
  end
endmodule

// File: rtl/vmseq_top.sv
// Voice macro sequencer with AXI4-Lite registers
`timescale 1ns/1ps
module vmseq_top (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // AXI4-Lite write
  input wire logic [7:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // Trigger pins and script load
  input wire logic [vmseq_pkg::NPIN-1:0] trig_pin,
  input wire logic load_we,
  input wire logic [vmseq_pkg::AW-1:0] load_addr,
  input wire logic [31:0] load_data,
  // Audio engine
  input wire logic [vmseq_pkg::NCH-1:0] audio_done,
  output logic [vmseq_pkg::NCH-1:0] play_start,
  output logic [15:0] play_index,
  output logic [7:0] play_loops,
  output logic silence_out,
  output logic sample_tick,
  output logic powered_up
);
  import vmseq_pkg::*;
  vmseq_flash_if fl();
  vmseq_script_rom u_rom (
    .ref_clk(ref_clk),
    .rst(rst),
    .fl(fl),
    .load_we(load_we),
    .load_addr(load_addr),
    .load_data(load_data)
  );
  // Configuration registers
  logic [7:0] edge_ff, trgen_ff, chan_ff, path_ff, vol_ff, mask_ff, stat_ff;
  logic [7:0] jmp_ff [NPIN];
  logic [AW-1:0] pc_ff;
  logic [31:0] cmd_ff;
  logic [NPIN-1:0] pin_ff;
  logic [NCH-1:0] busy_ff;
  logic [15:0] dly_ff [NCH];
  logic [1:0] tch_ff;
  logic boot_ff, pend_ff, swrst_ff, req_ff;
  logic [7:0] pend_mac_ff;
  vmseq_state_t st_ff;
  logic [15:0] div_ff;
  // Sample rate divider
  logic div_wrap;
  assign div_wrap = (div_ff == 16'(SAMPLE_DIV - 1));
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      div_ff <= 16'h0000;
      sample_tick <= 1'b0;
    end else begin
      div_ff <= div_wrap ? 16'h0000 : div_ff + 16'h0001;
      sample_tick <= div_wrap;
    end
  end
  // Trigger edge detect
  logic [NPIN-1:0] fall, rise, hit;
  logic trig_any;
  logic [2:0] trig_pin_no;
  assign fall = pin_ff & ~trig_pin;
  assign rise = ~pin_ff & trig_pin & edge_ff[NPIN-1:0];
  assign hit = (fall | rise) & trgen_ff[NPIN-1:0];
  assign trig_any = |hit;
  always_comb begin
    trig_pin_no = 3'd0;
    for (int i = NPIN - 1; i >= 0; i--) begin
      if (hit[i]) begin
        trig_pin_no = 3'(i);
      end
    end
  end
  // AXI write channel
  logic aw_ok, w_ok, wr_go, rd_go, wr_hit;
  logic [7:0] awa_ff, ara_ff;
  logic [31:0] wd_ff;
  logic awh_ff, wh_ff;
  assign aw_ok = s_awvalid & s_awready;
  assign w_ok = s_wvalid & s_wready;
  assign wr_go = awh_ff & wh_ff & ~s_bvalid;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      awh_ff <= 1'b0;
      wh_ff <= 1'b0;
      s_awready <= 1'b0;
      s_wready <= 1'b0;
      s_bvalid <= 1'b0;
      s_bresp <= RESP_OK;
      awa_ff <= 8'h00;
      wd_ff <= 32'h0000_0000;
    end else begin
      s_awready <= ~awh_ff & ~aw_ok;
      s_wready <= ~wh_ff & ~w_ok;
      if (aw_ok) begin
        awh_ff <= 1'b1;
        awa_ff <= s_awaddr;
      end
      if (w_ok) begin
        wh_ff <= 1'b1;
        wd_ff <= s_wdata;
      end
      if (wr_go) begin
        awh_ff <= 1'b0;
        wh_ff <= 1'b0;
        s_bvalid <= 1'b1;
        s_bresp <= wr_hit ? RESP_OK : RESP_ERR;
      end else if (s_bvalid & s_bready) begin
        s_bvalid <= 1'b0;
      end
    end
  end
  // Register decode
  logic wr_jmp, rd_hit;
  logic [2:0] wr_jidx, rd_jidx;
  assign wr_jidx = awa_ff[4:2];
  assign wr_jmp = (awa_ff[7:5] == OFS_JMP0[7:5]) && (wr_jidx < 3'(NPIN));
  assign wr_hit = wr_jmp || awa_ff == OFS_EDGE || awa_ff == OFS_TRGEN
    || awa_ff == OFS_CHAN || awa_ff == OFS_PATH || awa_ff == OFS_VOL
    || awa_ff == OFS_MASK || awa_ff == OFS_STAT || awa_ff == OFS_SWRST;
  logic sw_we;
  logic [7:0] sw_a, sw_d;
  assign sw_we = wr_go & wr_hit & s_wstrb[0];
  assign sw_a = awa_ff;
  assign sw_d = wd_ff[7:0];
  // Script configuration write
  logic cfg_we;
  logic [7:0] cfg_a, cfg_d;
  assign cfg_we = (st_ff == ST_EXEC) && (cmd_ff[31:28] == OP_CFG);
  assign cfg_a = cmd_ff[15:8];
  assign cfg_d = cmd_ff[7:0];
  logic any_we;
  logic [7:0] we_a, we_d;
  assign any_we = cfg_we | sw_we;
  assign we_a = cfg_we ? cfg_a : sw_a;
  assign we_d = cfg_we ? cfg_d : sw_d;
  logic pd_enter;
  assign pd_enter = (st_ff == ST_EXEC) && (cmd_ff[31:28] == OP_PD);
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      edge_ff <= 8'h00;
      trgen_ff <= RST_TRGEN;
      chan_ff <= 8'h00;
      path_ff <= RST_PATH;
      vol_ff <= RST_VOL;
      mask_ff <= 8'h00;
      stat_ff <= 8'h00;
      swrst_ff <= 1'b0;
      for (int i = 0; i < NPIN; i++) begin
        jmp_ff[i] <= 8'h00;
      end
    end else begin
      swrst_ff <= sw_we && sw_a == OFS_SWRST && sw_d[0];
      if (any_we) begin
        if (we_a == OFS_EDGE) edge_ff <= we_d;
        if (we_a == OFS_TRGEN) trgen_ff <= we_d;
        if (we_a == OFS_CHAN) chan_ff <= we_d;
        if (we_a == OFS_PATH) path_ff <= we_d;
        if (we_a == OFS_VOL) vol_ff <= we_d;
        if (we_a == OFS_MASK) mask_ff <= we_d;
        if (we_a == OFS_STAT) stat_ff <= we_d;
        if (we_a[7:5] == OFS_JMP0[7:5] && we_a[4:2] < 3'(NPIN)) begin
          jmp_ff[we_a[4:2]] <= we_d;
        end
      end
      if (pd_enter) begin
        path_ff <= RST_PATH;
        vol_ff <= RST_VOL;
      end
    end
  end
  // AXI read channel
  logic [31:0] rd_mux;
  assign rd_go = s_arvalid & s_arready;
  assign rd_jidx = s_araddr[4:2];
  assign rd_hit = ((s_araddr[7:5] == OFS_JMP0[7:5]) && rd_jidx < 3'(NPIN))
    || s_araddr == OFS_EDGE || s_araddr == OFS_TRGEN
    || s_araddr == OFS_CHAN || s_araddr == OFS_PATH
    || s_araddr == OFS_VOL || s_araddr == OFS_MASK
    || s_araddr == OFS_STAT || s_araddr == OFS_SWRST;
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (s_araddr)
      OFS_EDGE: rd_mux[7:0] = edge_ff;
      OFS_TRGEN: rd_mux[7:0] = trgen_ff;
      OFS_CHAN: rd_mux[7:0] = chan_ff;
      OFS_PATH: rd_mux[7:0] = path_ff;
      OFS_VOL: rd_mux[7:0] = vol_ff;
      OFS_MASK: rd_mux[7:0] = mask_ff;
      OFS_STAT: rd_mux = {10'h000, busy_ff, st_ff, pc_ff};
      default: begin
        if (rd_hit && s_araddr != OFS_SWRST) rd_mux[7:0] = jmp_ff[rd_jidx];
      end
    endcase
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_arready <= 1'b0;
      s_rvalid <= 1'b0;
      s_rdata <= 32'h0000_0000;
      s_rresp <= RESP_OK;
    end else begin
      s_arready <= ~s_rvalid & ~rd_go;
      if (rd_go) begin
        s_rvalid <= 1'b1;
        s_rdata <= rd_mux;
        s_rresp <= rd_hit ? RESP_OK : RESP_ERR;
      end else if (s_rvalid & s_rready) begin
        s_rvalid <= 1'b0;
      end
    end
  end
  // Script address of a macro: table of start words at low flash
  function automatic logic [AW-1:0] mac_addr(input logic [7:0] m);
    return {8'h00, m};
  endfunction
  assign fl.req = req_ff;
  assign fl.addr = pc_ff;
  logic [3:0] op;
  logic [1:0] sel;
  logic match;
  logic [NCH-1:0] play_mask;
  assign op = cmd_ff[31:28];
  assign sel = chan_ff[1:0];
  assign play_mask = (sel == CH_ALL) ? {NCH{1'b1}}
    : NCH'(1) << sel;
  // Status bits sit above the pins, so the full mask is compared
  assign match = ({stat_ff[1:0], pin_ff} & mask_ff) == mask_ff;
  // Sequencer
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_ff <= ST_FETCH;
      pc_ff <= mac_addr(MACRO_POI);
      cmd_ff <= 32'h0000_0000;
      req_ff <= 1'b1;
      pin_ff <= {NPIN{1'b1}};
      busy_ff <= '0;
      tch_ff <= 2'b00;
      boot_ff <= 1'b0;
      pend_ff <= 1'b0;
      pend_mac_ff <= 8'h00;
      play_start <= '0;
      play_index <= 16'h0000;
      play_loops <= 8'h00;
      silence_out <= 1'b0;
      powered_up <= 1'b1;
      for (int i = 0; i < NCH; i++) begin
        dly_ff[i] <= 16'h0000;
      end
    end else begin
      pin_ff <= trig_pin;
      play_start <= '0;
      busy_ff <= busy_ff & ~audio_done;
      for (int i = 0; i < NCH; i++) begin
        if (sample_tick && dly_ff[i] != 16'h0000) begin
          dly_ff[i] <= dly_ff[i] - 16'h0001;
        end
      end
      if (swrst_ff) begin
        st_ff <= ST_FETCH;
        pc_ff <= mac_addr(MACRO_POI);
        req_ff <= 1'b1;
        powered_up <= 1'b1;
        silence_out <= 1'b0;
        pend_ff <= 1'b0;
      end else if (trig_any) begin
        req_ff <= 1'b1;
        st_ff <= ST_FETCH;
        silence_out <= 1'b0;
        powered_up <= 1'b1;
        if (!powered_up) begin
          pc_ff <= mac_addr(MACRO_WAKE);
          pend_ff <= 1'b1;
          pend_mac_ff <= jmp_ff[trig_pin_no];
        end else begin
          pc_ff <= mac_addr(jmp_ff[trig_pin_no]);
        end
      end else begin
        unique case (st_ff)
          ST_OFF: ;
          ST_FETCH: begin
            st_ff <= ST_WAIT;
          end
          ST_WAIT: begin
            if (fl.ack) begin
              req_ff <= 1'b0;
              cmd_ff <= fl.data;
              st_ff <= ST_EXEC;
            end
          end
          ST_EXEC: begin
            pc_ff <= pc_ff + AW'(1);
            req_ff <= 1'b1;
            st_ff <= ST_FETCH;
            unique case (op)
              OP_PLAY: begin
                play_start <= play_mask;
                // Keep completions of other channels landing this cycle
                busy_ff <= (busy_ff & ~audio_done) | play_mask;
                play_index <= cmd_ff[23:8];
                play_loops <= cmd_ff[7:0];
              end
              OP_SILENCE, OP_DELAY: begin
                dly_ff[tch_ff] <= cmd_ff[15:0];
                silence_out <= (op == OP_SILENCE);
                req_ff <= 1'b0;
                st_ff <= ST_TIMER;
              end
              OP_WAIT: begin
                req_ff <= 1'b0;
                st_ff <= ST_AUDIO;
              end
              OP_MBR: begin
                if (match) pc_ff <= cmd_ff[AW-1:0];
              end
              OP_JMP: begin
                pc_ff <= cmd_ff[AW-1:0];
              end
              OP_EXE: begin
                pc_ff <= mac_addr(cmd_ff[7:0]);
              end
              OP_FINISH, OP_PD: begin
                if (pend_ff) begin
                  pend_ff <= 1'b0;
                  pc_ff <= mac_addr(pend_mac_ff);
                end else begin
                  req_ff <= 1'b0;
                  st_ff <= ST_OFF;
                  powered_up <= (op == OP_FINISH);
                end
              end
              default: ;
            endcase
          end
          ST_TIMER: begin
            if (dly_ff[tch_ff] == 16'h0000) begin
              silence_out <= 1'b0;
              req_ff <= 1'b1;
              st_ff <= ST_FETCH;
            end
          end
          ST_AUDIO: begin
            if (busy_ff == '0) begin
              req_ff <= 1'b1;
              st_ff <= ST_FETCH;
            end
          end
          default: st_ff <= ST_OFF;
        endcase
      end
      tch_ff <= (sel == CH_ALL) ? 2'b00 : sel;
    end
  end
  // Checks
  sequence s_wait_cmd;
    st_ff == ST_EXEC && op == OP_WAIT;
  endsequence
  property p_wait_holds;
    @(posedge ref_clk) disable iff (rst)
      s_wait_cmd ##1 (st_ff == ST_AUDIO && busy_ff != '0 && !trig_any
      && !swrst_ff) |=> st_ff == ST_AUDIO;
  endproperty
  a_wait_holds: assert property (p_wait_holds) else $error("wait left early");
  property p_jump;
    @(posedge ref_clk) disable iff (rst)
      (st_ff == ST_EXEC && op == OP_JMP && !trig_any && !swrst_ff)
      |=> pc_ff == $past(cmd_ff[AW-1:0]);
  endproperty
  a_jump: assert property (p_jump) else $error("jump target wrong");
  property p_play_ch;
    @(posedge ref_clk) disable iff (rst)
      (st_ff == ST_EXEC && op == OP_PLAY && !trig_any && !swrst_ff)
      |=> play_start == $past(play_mask) && play_start != '0;
  endproperty
  a_play_ch: assert property (p_play_ch) else $error("play channel wrong");
  property p_trig;
    @(posedge ref_clk) disable iff (rst)
      (trig_any && powered_up && !swrst_ff)
      |=> pc_ff == mac_addr($past(jmp_ff[trig_pin_no])) && st_ff == ST_FETCH;
  endproperty
  a_trig: assert property (p_trig) else $error("trigger not taken");
  property p_wake;
    @(posedge ref_clk) disable iff (rst)
      (trig_any && !powered_up && !swrst_ff)
      |=> pc_ff == mac_addr(MACRO_WAKE) && pend_ff;
  endproperty
  a_wake: assert property (p_wake) else $error("wake macro skipped");
  property p_pd;
    @(posedge ref_clk) disable iff (rst)
      (pd_enter && !pend_ff && !trig_any && !swrst_ff)
      |=> !powered_up && path_ff == RST_PATH && vol_ff == RST_VOL;
  endproperty
  a_pd: assert property (p_pd) else $error("power down wrong");
  property p_mask_off;
    @(posedge ref_clk) disable iff (rst)
      (((trig_pin ^ pin_ff) & trgen_ff[NPIN-1:0]) == '0) |-> !trig_any;
  endproperty
  a_mask_off: assert property (p_mask_off) else $error("masked pin fired");
  property p_tick;
    @(posedge ref_clk) disable iff (rst)
      sample_tick |=> !sample_tick [*2];
  endproperty
  a_tick: assert property (p_tick) else $error("sample tick too fast");
endmodule

// File: testbench/testbench.sv
// Self-checking bench for the voice macro sequencer
`timescale 1ns/1ps
module testbench;
  import vmseq_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] s_awaddr = 8'h00;
  logic s_awvalid = 1'b0;
  logic [31:0] s_wdata = 32'h0000_0000;
  logic s_wvalid = 1'b0;
  logic s_bready = 1'b0;
  logic [7:0] s_araddr = 8'h00;
  logic s_arvalid = 1'b0;
  logic s_rready = 1'b0;
  logic [NPIN-1:0] trig_pin = 6'h3f;
  logic load_we = 1'b0;
  logic [AW-1:0] load_addr = 16'h0000;
  logic [31:0] load_data = 32'h0000_0000;
  logic slow = 1'b0;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic [1:0] s_bresp, s_rresp, r;
  logic [31:0] s_rdata, d;
  logic [NCH-1:0] audio_done, play_start;
  logic [15:0] play_index;
  logic [7:0] play_loops;
  logic silence_out, sample_tick, powered_up, sil_prev;
  logic [2:0] m;
  logic [15:0] q_i [$];
  logic [2:0] q_m [$];
  logic [7:0] q_l [$];
  logic [7:0] lp;
  int q_t [$];
  int bad_count, cmp_count, cyc, t, t3, s, sil_len, sil_end, tick_t, tick_gap;
  // Address and word pairs of the script image
  localparam logic [47:0] IMG [32] = '{
    48'h0000_6000_0100, 48'h0001_6000_0700, 48'h0005_6000_0300,
    48'h0006_6000_0200, 48'h0007_6000_0400, 48'h0008_6000_0600,
    48'h0009_1009_9901, 48'h000a_0000_0000, 48'h0100_1012_3401,
    48'h0101_2000_0c01, 48'h0102_1022_2201, 48'h0103_2000_0c03,
    48'h0104_1033_3301, 48'h0105_4000_0000, 48'h0106_1044_4401,
    48'h0107_3000_0002, 48'h0108_9000_0001, 48'h0109_1055_5501,
    48'h010a_0000_0000, 48'h0200_1006_0601, 48'h0201_7000_0006,
    48'h0300_1005_0503, 48'h0301_0000_0000, 48'h0400_5000_ff00,
    48'h0401_1007_0101, 48'h0402_0000_0000, 48'h0600_2000_1455,
    48'h0601_8000_0000, 48'h0700_1001_1101, 48'h0701_0000_0000,
    48'hff00_1007_0201, 48'hff01_0000_0000};

  always #5 ref_clk = ~ref_clk;

  vmseq_top i_dut (.ref_clk(ref_clk), .rst(rst), .s_awaddr(s_awaddr),
    .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata),
    .s_wstrb(4'hf), .s_wvalid(s_wvalid), .s_wready(s_wready),
    .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
    .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
    .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
    .s_rready(s_rready), .trig_pin(trig_pin), .load_we(load_we),
    .load_addr(load_addr), .load_data(load_data), .audio_done(audio_done),
    .play_start(play_start), .play_index(play_index),
    .play_loops(play_loops), .silence_out(silence_out),
    .sample_tick(sample_tick), .powered_up(powered_up));

  vmseq_audio_model i_audio (.ref_clk(ref_clk), .rst(rst),
    .play_start(play_start), .slow(slow), .audio_done(audio_done));

  // Logs plays, silence length and tick spacing
  always @(posedge ref_clk) begin
    cyc++;
    if (!rst && play_start !== 3'b000) begin
      q_i.push_back(play_index);
      q_m.push_back(play_start);
      q_l.push_back(play_loops);
      q_t.push_back(cyc);
    end
    if (!rst && silence_out === 1'b1) sil_len++;
    if (!rst && sil_prev && silence_out !== 1'b1) sil_end = cyc;
    sil_prev = (silence_out === 1'b1);
    if (!rst && sample_tick === 1'b1) begin
      tick_gap = cyc - tick_t;
      tick_t = cyc;
    end
  end

  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] a, input logic [31:0] e);
    cmp_count++;
    if (a !== e) begin
      bad_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, a, e);
    end
  endtask

  task automatic rng(input int a, input int lo, input int hi);
    chk(32'(a >= lo && a <= hi), 32'h0000_0001);
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] v);
    int n;
    @(posedge ref_clk);
    s_awaddr <= a;
    s_wdata <= v;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    for (n = 0; n < 2000; n++) begin
      @(posedge ref_clk);
      if (s_awready === 1'b1) s_awvalid <= 1'b0;
      if (s_wready === 1'b1) s_wvalid <= 1'b0;
      if (s_bvalid === 1'b1) begin
        r = s_bresp;
        s_bready <= 1'b0;
        return;
      end
    end
    chk(32'h0000_0000, 32'h0000_0001);
  endtask

  task automatic axr(input logic [7:0] a);
    int n;
    @(posedge ref_clk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    for (n = 0; n < 2000; n++) begin
      @(posedge ref_clk);
      if (s_arready === 1'b1) s_arvalid <= 1'b0;
      if (s_rvalid === 1'b1) begin
        d = s_rdata;
        r = s_rresp;
        s_rready <= 1'b0;
        return;
      end
    end
    chk(32'h0000_0000, 32'h0000_0001);
  endtask

  task automatic pin(input int p, input logic v);
    @(posedge ref_clk);
    trig_pin[p] <= v;
    repeat (4) @(posedge ref_clk);
  endtask

  task automatic pulse(input int p);
    pin(p, 1'b0);
    pin(p, 1'b1);
  endtask

  task automatic clr;
    q_i.delete();
    q_m.delete();
    q_l.delete();
    q_t.delete();
  endtask

  // Waits for a play of the given prompt, counting others passed over
  task automatic find(input logic [15:0] idx);
    s = 0;
    for (int n = 0; n < 40000; n++) begin
      @(posedge ref_clk);
      while (q_i.size() > 0) begin
        m = q_m.pop_front();
        lp = q_l.pop_front();
        t = q_t.pop_front();
        if (q_i.pop_front() === idx) return;
        s++;
      end
    end
    chk({16'h0000, idx}, 32'h0000_ffff);
  endtask

  task automatic quiet;
    clr();
    repeat (100) @(posedge ref_clk);
    chk(q_i.size(), 32'h0000_0000);
  endtask

  task automatic t_regs;
    axr(OFS_TRGEN);
    chk(d, {24'h00_0000, RST_TRGEN});
    axw(8'h30, 32'h0000_0001);
    chk(r, RESP_ERR);
    axr(8'h34);
    chk(r, RESP_ERR);
  endtask

  // Power-on macro straight after reset, then again after a soft reset
  task automatic t_boot;
    clr();
    sil_len = 0;
    find(16'h1234);
    chk(m, 3'b001);
    find(16'h2222);
    chk(m, 3'b010);
    find(16'h3333);
    chk(m, 3'b111);
    t3 = t;
    find(16'h4444);
    rng(t - t3, 190, 40000);
    find(16'h5555);
    rng(sil_len, SAMPLE_DIV, 2 * SAMPLE_DIV + 4);
    rng(t - sil_end, 1, SAMPLE_DIV + 8);
    chk(tick_gap, SAMPLE_DIV);
    repeat (10) @(posedge ref_clk);
    chk(powered_up, 1'b1);
    axr(OFS_CHAN);
    chk(d[1:0], CH_ALL);
    slow <= 1'b0;
    clr();
    axw(OFS_SWRST, 32'h0000_0001);
    find(16'h1234);
    chk(m, 3'b111);
    find(16'h5555);
  endtask

  task automatic t_chan;
    axw(OFS_CHAN, 32'h0000_0001);
    axr(OFS_CHAN);
    chk(d, 32'h0000_0001);
    axw(OFS_JMP0 + 8'h08, 32'h0000_0005);
    clr();
    pulse(2);
    find(16'h0505);
    chk(m, 3'b010);
    chk(lp, 8'h03);
  endtask

  task automatic t_preempt;
    axw(OFS_JMP0 + 8'h08, 32'h0000_0006);
    pulse(2);
    find(16'h0606);
    find(16'h0606);
    axw(OFS_JMP0 + 8'h08, 32'h0000_0005);
    clr();
    pulse(2);
    find(16'h0505);
    quiet();
  endtask

  task automatic t_rise;
    axw(OFS_EDGE, 32'h0000_0004);
    axw(OFS_JMP0 + 8'h08, 32'h0000_0006);
    pin(2, 1'b0);
    find(16'h0606);
    axw(OFS_JMP0 + 8'h08, 32'h0000_0005);
    clr();
    pin(2, 1'b1);
    find(16'h0505);
    quiet();
    axw(OFS_EDGE, 32'h0000_0000);
  endtask

  task automatic t_enable;
    axw(OFS_TRGEN, 32'h0000_003b);
    pulse(2);
    quiet();
    axw(OFS_TRGEN, 32'h0000_003f);
    pulse(2);
    find(16'h0505);
    chk(s, 32'h0000_0000);
  endtask

  task automatic t_mask;
    axw(OFS_JMP0 + 8'h0c, 32'h0000_0007);
    axw(OFS_MASK, 32'h0000_0008);
    clr();
    pin(3, 1'b0);
    find(16'h0701);
    pin(3, 1'b1);
    axw(OFS_MASK, 32'h0000_0001);
    clr();
    pulse(3);
    find(16'h0702);
    chk(s, 32'h0000_0000);
  endtask

  task automatic t_pd;
    axw(OFS_JMP0 + 8'h10, 32'h0000_0008);
    pulse(4);
    for (int n = 0; n < 300 && powered_up !== 1'b0; n++) @(posedge ref_clk);
    chk(powered_up, 1'b0);
    axr(OFS_VOL);
    chk(d, {24'h00_0000, RST_VOL});
    axw(OFS_JMP0 + 8'h10, 32'h0000_0009);
    clr();
    pulse(4);
    find(16'h0111);
    chk(s, 32'h0000_0000);
    find(16'h0999);
    chk(s, 32'h0000_0000);
  endtask

  initial begin
    repeat (60000) @(posedge ref_clk);
    chk(32'h0000_0000, 32'h0000_0001);
    final_report();
  end

  initial begin
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    for (int i = 0; i < 32; i++) begin
      @(posedge ref_clk);
      load_we <= 1'b1;
      load_addr <= IMG[i][47:32];
      load_data <= IMG[i][31:0];
    end
    @(posedge ref_clk);
    load_we <= 1'b0;
    // Second reset so the power-on macro runs from a loaded store
    rst <= 1'b1;
    slow <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    t_boot();
    t_regs();
    t_chan();
    t_preempt();
    t_rise();
    t_enable();
    t_mask();
    t_pd();
    final_report();
  end
endmodule

// File: testbench/vmseq_audio_model.sv
// Audio engine stand-in that answers play commands per channel
`timescale 1ns/1ps
module vmseq_audio_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Play requests and answer pace
  input wire logic [vmseq_pkg::NCH-1:0] play_start,
  input wire logic slow,
  // Completion pulses
  output logic [vmseq_pkg::NCH-1:0] audio_done
);
  import vmseq_pkg::*;
  int cnt [NCH];
  // One countdown per channel, restarted by a new play
  always @(posedge ref_clk) begin
    for (int c = 0; c < NCH; c++) begin
      audio_done[c] <= 1'b0;
      if (rst) begin
        cnt[c] <= 0;
      end else if (play_start[c] === 1'b1) begin
        cnt[c] <= slow ? 200 : 3;
      end else if (cnt[c] == 1) begin
        cnt[c] <= 0;
        audio_done[c] <= 1'b1;
      end else if (cnt[c] > 1) begin
        cnt[c] <= cnt[c] - 1;
      end
    end
  end
endmodule
